// [logic/eeprom_host.sv]
// host controller driving a parallel eeprom with software data protection
// Contract
// - host precedes protected data with three fixed command writes
// - host disarms with a six-step deactivation sequence
// - host issues command sequences without interleaved accesses
// - chip select driven low by the sequencer for each access, oe and we shared
// - host keeps page address bits fixed within one page load
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_host_defs.svh"
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int AW       = 13,
  parameter int PAGE_MAX = `PAGE_BYTES,
  parameter int PROG_CYC = `PROGRAM_TIME_CYC,
  parameter int GAP_CYC  = `LOAD_GAP_CYC,
  parameter logic [AW-1:0] ARM_A0 = `ARM_ADDR0,
  parameter logic [AW-1:0] ARM_A1 = `ARM_ADDR1,
  parameter logic [AW-1:0] ARM_A2 = `ARM_ADDR2,
  parameter logic [7:0]    ARM_D0 = `ARM_DATA0,
  parameter logic [7:0]    ARM_D1 = `ARM_DATA1,
  parameter logic [7:0]    ARM_D2 = `ARM_DATA2,
  parameter logic [7:0]    DIS_D2 = `DISARM_DATA2,
  parameter logic [7:0]    DIS_D5 = `DISARM_DATA5
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          req_valid,
  input  wire cmd_t          req_cmd,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [6:0]    req_len,
  output logic               req_ready,
  input  wire logic          wr_valid,
  input  wire logic [7:0]    wr_data,
  output logic               wr_ready,
  output logic               rd_valid,
  output logic [7:0]         rd_data,
  output logic               done,
  output logic               timeout,
  output logic [AW-1:0]      mem_addr,
  output logic               mem_ce_n,
  output logic               mem_oe_n,
  output logic               mem_we_n,
  output logic [7:0]         mem_dq_o,
  output logic               mem_dq_oe,
  input  wire logic [7:0]    mem_dq_i
);
  localparam int TW = 24;
  localparam int STB = (`STROBE_CYC < 1) ? 1 : `STROBE_CYC;

  state_t        state_r;
  cmd_t          cmd_r;
  logic [2:0]    step_r;
  logic [2:0]    nsteps_r;
  logic [6:0]    left_r;
  logic [AW-1:0] base_r;
  logic [7:0]    last_r;
  logic [7:0]    prev_r;
  logic          prev_ok_r;
  logic [TW-1:0] prog_r;
  logic [7:0]    dq_s1_r;
  logic [7:0]    dq_s2_r;
  logic          tload;
  logic [TW-1:0] tcount;
  logic          texp;

  strobe_timer #(.W(TW)) u_timer (
    .clk     (clk),
    .resetn  (resetn),
    .load    (tload),
    .count   (tcount),
    .expired (texp)
  );

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      dq_s1_r <= mem_dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ----------------------------------------
  // command step table
  // ----------------------------------------
  logic          in_cmd;
  logic [AW-1:0] step_addr;
  logic [7:0]    step_data;
  // deactivation: aa,55,80,aa,55,20 at a0,a1,a2,a0,a1,a2
  always_comb begin
    in_cmd    = (step_r < nsteps_r);
    step_addr = base_r + AW'(nsteps_r - left_r[2:0]);
    step_data = wr_data;
    unique case (step_r)
      3'h0: begin step_addr = ARM_A0; step_data = ARM_D0; end
      3'h1: begin step_addr = ARM_A1; step_data = ARM_D1; end
      3'h2: begin
        step_addr = ARM_A2;
        step_data = (cmd_r == cmd_unprot) ? DIS_D2 : ARM_D2;
      end
      3'h3: begin step_addr = ARM_A0; step_data = ARM_D0; end
      3'h4: begin step_addr = ARM_A1; step_data = ARM_D1; end
      3'h5: begin step_addr = ARM_A2; step_data = DIS_D5; end
      default: begin step_addr = ARM_A0; step_data = ARM_D0; end
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic more;
  // the strobe has already advanced step_r or left_r, so test what remains
  assign more = in_cmd || (left_r != 7'h00);
  always_comb begin
    tload  = 1'b0;
    tcount = TW'(STB);
    if (state_r == st_setup || state_r == st_rd) begin
      tload = (prog_r == '0) ? 1'b1 : 1'b0;
      if (state_r == st_rd) tload = 1'b1;
      if (state_r == st_setup) tload = 1'b1;
    end else if (state_r == st_strb && texp) begin
      tload  = 1'b1;
      tcount = TW'(GAP_CYC);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= st_idle;
      cmd_r     <= cmd_read;
      step_r    <= 3'h0;
      nsteps_r  <= 3'h0;
      left_r    <= 7'h00;
      base_r    <= '0;
      last_r    <= 8'h00;
      prev_r    <= 8'h00;
      prev_ok_r <= 1'b0;
      prog_r    <= '0;
      req_ready <= 1'b0;
      wr_ready  <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
      done      <= 1'b0;
      timeout   <= 1'b0;
      mem_addr  <= '0;
      mem_ce_n  <= 1'b1;
      mem_oe_n  <= 1'b1;
      mem_we_n  <= 1'b1;
      mem_dq_o  <= 8'h00;
      mem_dq_oe <= 1'b0;
    end else begin
      rd_valid  <= 1'b0;
      done      <= 1'b0;
      timeout   <= 1'b0;
      wr_ready  <= 1'b0;
      req_ready <= (state_r == st_idle) && !req_valid;
      if (prog_r != '0) prog_r <= prog_r - TW'(1);
      unique case (state_r)
        st_idle: if (req_valid && req_ready) begin
          req_ready <= 1'b0;
          cmd_r     <= req_cmd;
          // page confined to one 64-byte row
          base_r    <= {req_addr[AW-1:`PAGE_LSB], req_addr[`PAGE_LSB-1:0]};
          left_r    <= (req_cmd == cmd_read) ? 7'h01 :
                       (req_len == 7'h00) ? 7'h01 :
                       (req_len > 7'(PAGE_MAX)) ? 7'(PAGE_MAX) : req_len;
          step_r    <= 3'h0;
          // three arming writes, six to disarm, none for plain
          nsteps_r  <= (req_cmd == cmd_prot) ? 3'h3 :
                       (req_cmd == cmd_unprot) ? 3'h6 : 3'h0;
          if (req_cmd == cmd_unprot) left_r <= 7'h00;
          state_r   <= (req_cmd == cmd_read) ? st_rd : st_setup;
          mem_addr  <= req_addr;
        end
        st_setup: begin
          // strobes kept inactive until data is in hand
          if (in_cmd || wr_valid) begin
            mem_addr  <= in_cmd ? step_addr
                         : {base_r[AW-1:`PAGE_LSB], base_r[`PAGE_LSB-1:0]};
            mem_dq_o  <= in_cmd ? step_data : wr_data;
            if (!in_cmd) last_r <= wr_data;
            if (!in_cmd) wr_ready <= 1'b1;
            mem_dq_oe <= 1'b1;
            mem_oe_n  <= 1'b1;
            mem_ce_n  <= 1'b0; // select only for this access, oe and we common
            mem_we_n  <= 1'b0;
            state_r   <= st_strb;
          end
        end
        st_strb: if (texp) begin
          // select held one cycle past the write strobe so data latches on we alone
          mem_we_n <= 1'b1;
          if (in_cmd) step_r <= step_r + 3'h1;
          else begin
            left_r <= left_r - 7'h01;
            base_r <= {base_r[AW-1:`PAGE_LSB], base_r[`PAGE_LSB-1:0] + 6'h01};
          end
          state_r <= st_gap;
        end
        st_gap: begin
          mem_dq_oe <= 1'b0;
          mem_ce_n  <= 1'b1;
          // sequence issued back to back, well inside the byte load limit
          if (more) state_r <= st_setup;
          else if (texp) begin
            prog_r    <= TW'(PROG_CYC);
            prev_ok_r <= 1'b0;
            state_r   <= (cmd_r == cmd_unprot) ? st_done : st_rd;
            mem_addr  <= {base_r[AW-1:`PAGE_LSB], base_r[`PAGE_LSB-1:0] - 6'h01};
          end
        end
        st_rd: begin
          mem_ce_n <= 1'b0;
          mem_oe_n <= 1'b0;
          state_r  <= st_rdgap;
        end
        st_rdgap: if (texp) begin
          mem_ce_n <= 1'b1;
          mem_oe_n <= 1'b1;
          state_r  <= (cmd_r == cmd_read) ? st_done : st_poll;
          rd_data  <= dq_s2_r;
          rd_valid <= (cmd_r == cmd_read);
        end
        st_poll: begin
          // finished when bit six stops toggling and bit seven matches the last byte written
          prev_r    <= rd_data;
          prev_ok_r <= 1'b1;
          if (prev_ok_r
              && rd_data[`ALTERNATING_BIT] == prev_r[`ALTERNATING_BIT]
              && rd_data[`COMPLEMENT_BIT] == last_r[`COMPLEMENT_BIT]) begin
            state_r <= st_done;
          end else if (prog_r == '0) begin
            timeout <= 1'b1;
            state_r <= st_done;
          end else state_r <= st_rd;
        end
        st_done: if (cmd_r != cmd_unprot || prog_r == '0) begin
          // deactivation needs the full program time
          done    <= 1'b1;
          state_r <= st_idle;
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_no_we_oe: assert property (@(posedge clk) disable iff (!resetn)
    !mem_we_n |-> mem_oe_n && !mem_ce_n) else $error("write strobe with oe low");
  a_cmd_order: assert property (@(posedge clk) disable iff (!resetn)
    $fell(mem_we_n) && cmd_r == cmd_prot && step_r == 3'h1 |-> mem_addr == ARM_A1
    && mem_dq_o == ARM_D1) else $error("arming step wrong");
  a_dis_last: assert property (@(posedge clk) disable iff (!resetn)
    $fell(mem_we_n) && cmd_r == cmd_unprot && step_r == 3'h5 |-> mem_dq_o == DIS_D5)
    else $error("disarm step wrong");
  a_page_fixed: assert property (@(posedge clk) disable iff (!resetn)
    $fell(mem_we_n) && !in_cmd && $past(state_r) == st_setup
    |-> mem_addr[AW-1:`PAGE_LSB] == base_r[AW-1:`PAGE_LSB]) else $error("page moved");
  a_strobe_width: assert property (@(posedge clk) disable iff (!resetn)
    $fell(mem_we_n) |-> !mem_we_n [*2]) else $error("write pulse too short");
  a_data_held: assert property (@(posedge clk) disable iff (!resetn)
    !mem_we_n |=> mem_dq_oe) else $error("data released early");
  a_unprot_wait: assert property (@(posedge clk) disable iff (!resetn)
    done && cmd_r == cmd_unprot |-> prog_r == '0) else $error("disarm done early");
  a_poll_rd: assert property (@(posedge clk) disable iff (!resetn)
    !mem_oe_n |-> mem_we_n && !mem_dq_oe) else $error("read with write");
  c_prot: cover property (@(posedge clk) done && cmd_r == cmd_prot);
  c_unprot: cover property (@(posedge clk) done && cmd_r == cmd_unprot);
  c_plain: cover property (@(posedge clk) done && cmd_r == cmd_plain);
  c_timeout: cover property (@(posedge clk) timeout);
endmodule // eeprom_host
`default_nettype wire

// [logic/eeprom_host_defs.svh]
// timing counts, command defaults and field positions for the eeprom host controller
`ifndef EEPROM_HOST_DEFS_SVH
`define EEPROM_HOST_DEFS_SVH
`define CLK_MHZ            50
`define STROBE_NS          60
`define STROBE_CYC         ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define BYTE_LOAD_US       100
`define LOAD_GAP_US        20
`define LOAD_GAP_CYC       (`LOAD_GAP_US * `CLK_MHZ)
`define PROGRAM_TIME_MS    5
`define PROGRAM_TIME_CYC   (`PROGRAM_TIME_MS * 1000 * `CLK_MHZ)
`define PAGE_BYTES         64
`define PAGE_LSB           6
`define COMPLEMENT_BIT     7
`define ALTERNATING_BIT    6
`define ARM_ADDR0          13'h1555
`define ARM_ADDR1          13'h0AAA
`define ARM_ADDR2          13'h1555
`define ARM_DATA0          8'hAA
`define ARM_DATA1          8'h55
`define ARM_DATA2          8'hA0
`define DISARM_DATA2       8'h80
`define DISARM_DATA5       8'h20
`endif

// [logic/eeprom_host_pkg.sv]
// types for the eeprom host controller
package eeprom_host_pkg;
  typedef enum logic [1:0] {
    cmd_read  = 2'h0,
    cmd_plain = 2'h1,
    cmd_prot  = 2'h2,
    cmd_unprot = 2'h3
  } cmd_t;
  typedef enum logic [7:0] {
    st_idle  = 8'h01,
    st_setup = 8'h02,
    st_strb  = 8'h04,
    st_gap   = 8'h08,
    st_rd    = 8'h10,
    st_rdgap = 8'h20,
    st_poll  = 8'h40,
    st_done  = 8'h80
  } state_t;
endpackage

// [logic/strobe_timer.sv]
// down counter giving a one-cycle expiry pulse
`timescale 1ns/1ns
`default_nettype none
module strobe_timer #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expired
);
  logic [W-1:0] cnt_r;
  logic         run_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r   <= '0;
      run_r   <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        cnt_r <= count;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r <= W'(1)) begin
          run_r   <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_r <= cnt_r - W'(1);
        end
      end
    end
  end
endmodule // strobe_timer
`default_nettype wire

// [sim/eeprom_device_model.sv]
// behavioural parallel eeprom with software write protection and status bits
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_host_defs.svh"
module eeprom_device_model #(
  parameter int AW   = 13,
  parameter int LCYC = 20,
  parameter int PCYC = 100
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] addr,
  input  wire logic          ce_n,
  input  wire logic          oe_n,
  input  wire logic          we_n,
  input  wire logic [7:0]    din,
  output logic [7:0]         dout,
  output logic               drive
);
  logic [7:0]    mem [0:(1<<AW)-1];
  logic [AW-1:0] pa [$];
  logic [7:0]    pd [$];
  logic [7:0]    last_d = 8'h00;
  logic          prot   = 1'b0; // shipped disarmed; no reset pin, so it outlives host resets
  logic          win    = 1'b0;
  logic          unarm  = 1'b0;
  logic          tgl    = 1'b0;
  logic [AW-1:0] sa;
  int            s      = 0;
  int            lcnt   = 0;
  int            pcnt   = 0;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // command steps share the host's parameter set
  assign sa = (s % 3 == 0) ? `ARM_ADDR0 : (s % 3 == 1) ? `ARM_ADDR1 : `ARM_ADDR2;
  // byte taken on write strobe rising, select low and oe high only
  always @(posedge we_n) begin
    if (ce_n === 1'b0 && oe_n === 1'b1 && pcnt == 0) begin
      if (!win && addr === sa && (din === `ARM_DATA0 && s % 3 == 0
          || din === `ARM_DATA1 && s % 3 == 1 || s == 5 && din === `DISARM_DATA5
          || s == 2 && (din === `ARM_DATA2 || din === `DISARM_DATA2))) begin
        if (s == 2 && din === `ARM_DATA2) begin
          prot = 1'b1; // armed whatever it was, page window opens
          win = 1'b1;
          lcnt = LCYC;
          s = 0;
        end else if (s == 5) begin
          unarm = 1'b1;
          pcnt = PCYC;
          s = 0;
        end else begin
          s = s + 1;
        end
      end else if (win || (s == 0 && !prot)) begin
        win = 1'b1; // each byte restarts the load timer
        pa.push_back(addr);
        pd.push_back(din);
        last_d = din;
        lcnt = LCYC;
      end else begin
        s = 0; // armed stray write dropped, broken sequence aborted
      end
    end
  end
  always @(posedge clk) begin
    if (lcnt > 0) begin
      lcnt = lcnt - 1;
      if (lcnt == 0) begin
        win = 1'b0; // protection flag untouched: guarded again only when prot is set
        if (pa.size() > 0) pcnt = PCYC;
      end
    end else if (pcnt > 0) begin
      pcnt = pcnt - 1;
      if (pcnt == 0) begin
        while (pa.size() > 0) mem[pa.pop_front()] = pd.pop_front();
        if (unarm) prot = 1'b0; // disarm only after the program time
        unarm = 1'b0;
      end
    end
  end
  always @(negedge oe_n) if (ce_n === 1'b0 && lcnt + pcnt > 0) tgl = ~tgl;
  assign drive = ce_n === 1'b0 && oe_n === 1'b0 && we_n === 1'b1;
  assign dout  = (lcnt + pcnt > 0) ? {~last_d[7], tgl, last_d[5:0]} : mem[addr];
endmodule // eeprom_device_model
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench: host controller against the device model
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import eeprom_host_pkg::*;
  logic        clk       = 1'b0;
  logic        resetn    = 1'b0;
  logic        req_valid = 1'b0;
  logic        wr_valid  = 1'b0;
  cmd_t        req_cmd   = cmd_read;
  logic [12:0] req_addr  = 13'h0000;
  logic [6:0]  req_len   = 7'h01;
  logic [7:0]  wr_data   = 8'h00;
  logic [7:0]  bus_last  = 8'h00;
  logic        req_ready, wr_ready, rd_valid, done, timeout, ce_n, oe_n, we_n, dq_oe, drv;
  logic [12:0] mem_addr;
  logic [7:0]  rd_data, dq_o, dq_i, dev_out;
  logic [7:0]  exp_mem [int];
  logic [7:0]  wq [$];
  bit          eprot = 1'b0;
  int          err_total = 0;
  int          samples_checked = 0;
  initial forever #10 clk = ~clk;
  // released bus floats: show the inverse of what it last carried
  assign dq_i = dq_oe ? dq_o : drv ? dev_out : ~bus_last;
  always @(posedge clk) if (dq_oe === 1'b1 || drv === 1'b1) bus_last <= dq_i;
  eeprom_host #(.PROG_CYC(400), .GAP_CYC(8)) eeprom_host_inst (.clk(clk), .resetn(resetn),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_len(req_len),
    .req_ready(req_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .timeout(timeout),
    .mem_addr(mem_addr), .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
    .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq_i));
  eeprom_device_model eeprom_device_model_inst (.clk(clk), .addr(mem_addr), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .din(dq_o), .dout(dev_out), .drive(drv));
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input cmd_t c, input logic [12:0] a, input bit acc, output logic [7:0] rv);
    int i, k, tmo;
    logic fin;
    i = 0; k = 0; tmo = 0; fin = 1'b0; rv = 8'h00;
    // ready only rises while no request is offered, so wait for it first
    do begin @(negedge clk); k++; end while (req_ready !== 1'b1 && k < 50);
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a;
    req_len = 7'(wq.size());
    @(negedge clk);
    req_valid = 1'b0;
    while (!fin && k < 20000) begin
      wr_valid = i < wq.size();
      if (i < wq.size()) wr_data = wq[i];
      @(negedge clk);
      k++;
      if (wr_ready === 1'b1) i++;
      if (rd_valid === 1'b1) rv = rd_data;
      if (timeout === 1'b1) tmo++;
      fin = done === 1'b1;
    end
    chk_flag(fin, 1'b1);
    if (acc) chk_flag(tmo == 0, 1'b1);
  endtask
  task automatic wr(input cmd_t c, input logic [12:0] a, input int n);
    logic [7:0] rv;
    bit acc;
    acc = c != cmd_plain || !eprot;
    wq.delete();
    repeat (n) wq.push_back(8'($urandom));
    if (acc) foreach (wq[i]) exp_mem[{a[12:6], 6'(a[5:0] + i)}] = wq[i];
    if (c == cmd_prot) eprot = 1'b1;
    if (c == cmd_unprot) eprot = 1'b0;
    run(c, a, acc, rv);
  endtask
  task automatic rd_chk(input logic [12:0] a);
    logic [7:0] rv;
    wq.delete();
    run(cmd_read, a, 1'b1, rv);
    chk_byte(rv, exp_mem.exists(a) ? exp_mem[a] : 8'hFF);
  endtask
  task automatic note(input string nm);
    $display("test %s ended, mismatches %0d", nm, err_total);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles the tests take
  initial begin
    #1500000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    logic [12:0] a;
    int n;
    void'($urandom(79628));
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    wr(cmd_plain, 13'h0100, 3);
    rd_chk(13'h0100);
    rd_chk(13'h0102);
    note("plain");
    wr(cmd_prot, 13'h0270, 64);
    for (int i = 0; i < 64; i += 7) begin
      rd_chk(13'h0240 + 13'(i));
    end
    wr(cmd_plain, 13'h0100, 1);
    rd_chk(13'h0100);
    note("armed");
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    wr(cmd_plain, 13'h0101, 1);
    rd_chk(13'h0101);
    wr(cmd_prot, 13'h013F, 1);
    rd_chk(13'h013F);
    wr(cmd_plain, 13'h013F, 1);
    rd_chk(13'h013F);
    note("rearm");
    wr(cmd_unprot, 13'h0000, 0);
    wr(cmd_plain, 13'h0102, 2);
    rd_chk(13'h0102);
    rd_chk(13'h0103);
    note("disarm");
    // random page loads away from the command addresses
    repeat (6) begin
      a = {2'b11, 11'($urandom)};
      n = 1 + $urandom % 8;
      wr(($urandom % 2) ? cmd_plain : cmd_prot, a, n);
      rd_chk({a[12:6], 6'(a[5:0] + 6'(n - 1))});
    end
    note("random");
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
